// ### mfc_config_bits.sv
// Purpose: Processor-writable configuration bits for the metering front end
// Assumes: Byte register port from the processor, one 200 MHz clock
// Notes:   Reads answer one cycle after the strobe; unmapped reads give zero
//
// How it works
// RL1 - Converter enable powers converter and reference
// RL2 - Battery bit loads battery, routes to converter
// RL3 - Boot end address is size times 1024
// RL4 - Engine clock 10 MHz when set, else 5
// RL5 - Program start field gives engine fetch start
// RL6 - Chop mode 01 positive, 10 reversed
// RL7 - Mode 00 toggles, inserts alternate frame
// RL8 - Mode 11 toggles, never inserts
// RL9 - Current chopping only with master enable
// RL10 - Per-channel enables under the master
// RL11 - Written bits read back, reserved read zero
// RL12 - Reset and wake load values, wake keeps battery
`timescale 1ns/1ps
module mfc_config_bits (
    input wire logic mclk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic wake, // Wake pulse, reloads defaults except battery load
    input mfc_pkg::mfc_req_type req, // Processor register request
    output logic [7:0] rdData, // Read data, one cycle after read strobe
    input wire logic muxFrameSync, // Multiplexer frame sync
    input wire logic accumEnd, // Sync edge ends an accumulation interval
    output logic converterEnable, // Converter and reference bias on
    output logic batteryLoadEnable, // Battery load and routing on
    output logic [17:0] bootEndAddr, // End of boot region
    output logic [7:0] engineProgramStart, // Engine program start address
    output logic engineEnable, // Engine enabled
    output logic engineClkEn, // Engine clock enable pulse
    output logic chopPolarity, // Bandgap chop polarity
    output logic alternateFrameRequest, // Alternate frame request pulse
    output logic [3:0] currentChopEnable // Chop enable per current channel
);
    import mfc_pkg::*;

    typedef struct packed {
        mfc_cfg_type cfg; // Configuration bits
        logic [7:0] rd; // Read data
        logic [5:0] divCnt; // Engine clock divider
        logic tick; // Engine clock pulse
        logic [17:0] bootEnd; // Boot end address
        logic [3:0] chopOut; // Gated channel enables
    } mfc_state_type;

    localparam mfc_cfg_type CFG_DEFAULT = '{
        bootRegionSize: BOOT_REGION_RESET,
        engineProgramStart: PROGRAM_START_RESET,
        default: '0
    };

    mfc_state_type s_q;
    mfc_state_type s_d;

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    // RL11 reserved bits read zero
    function automatic logic [7:0] readMux(input logic [15:0] a, input mfc_cfg_type c);
        logic [7:0] v;
        v = 8'h00;
        if (a == ENGINE_CLOCK_AND_ENABLE_OFS) begin
            v[ENGINE_FAST_CLOCK_BIT] = c.engineFastClockSelect;
            v[ENGINE_ENABLE_BIT] = c.engineEnable;
        end else if (a == BANDGAP_CHOP_CONTROL_OFS) begin
            v[CHOP_MODE_LSB +: 2] = c.chopMode;
        end else if (a == CONVERTER_POWER_CONTROL_OFS) begin
            v[CONVERTER_ENABLE_BIT] = c.converterEnable;
        end else if (a == BATTERY_TEST_CONTROL_OFS) begin
            v[BATTERY_LOAD_BIT] = c.batteryLoadEnable;
        end else if (a == BOOT_REGION_SIZE_OFS) begin
            v = c.bootRegionSize;
        end else if (a == ENGINE_PROGRAM_BASE_OFS) begin
            v = c.engineProgramStart;
        end else if (a == CURRENT_CHOP_MASTER_OFS) begin
            v[CHOP_MASTER_BIT] = c.chopMaster;
        end else if (a == CURRENT_CHOP_CHANNELS_AB_OFS) begin
            v[CHOP_LOW_CHANNEL_BIT] = c.chopChannels[0];
            v[CHOP_HIGH_CHANNEL_BIT] = c.chopChannels[1];
        end else if (a == CURRENT_CHOP_CHANNELS_CD_OFS) begin
            v[CHOP_LOW_CHANNEL_BIT] = c.chopChannels[2];
            v[CHOP_HIGH_CHANNEL_BIT] = c.chopChannels[3];
        end
        return v;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // Wake beats a write in the same cycle, so defaults are never half applied
    always_comb begin
        s_d = s_q;
        s_d.rd = req.rdEn ? readMux(req.addr, s_q.cfg) : 8'h00;
        if (wake) begin
            // RL12 wake reload, battery kept
            s_d.cfg = CFG_DEFAULT;
            s_d.cfg.batteryLoadEnable = s_q.cfg.batteryLoadEnable;
        end else if (req.wrEn) begin
            // RL11 writable bits stored
            if (req.addr == ENGINE_CLOCK_AND_ENABLE_OFS) begin
                s_d.cfg.engineFastClockSelect = req.wrData[ENGINE_FAST_CLOCK_BIT];
                s_d.cfg.engineEnable = req.wrData[ENGINE_ENABLE_BIT];
            end else if (req.addr == BANDGAP_CHOP_CONTROL_OFS) begin
                s_d.cfg.chopMode = req.wrData[CHOP_MODE_LSB +: 2];
            end else if (req.addr == CONVERTER_POWER_CONTROL_OFS) begin
                s_d.cfg.converterEnable = req.wrData[CONVERTER_ENABLE_BIT];
            end else if (req.addr == BATTERY_TEST_CONTROL_OFS) begin
                s_d.cfg.batteryLoadEnable = req.wrData[BATTERY_LOAD_BIT];
            end else if (req.addr == BOOT_REGION_SIZE_OFS) begin
                s_d.cfg.bootRegionSize = req.wrData;
            end else if (req.addr == ENGINE_PROGRAM_BASE_OFS) begin
                s_d.cfg.engineProgramStart = req.wrData;
            end else if (req.addr == CURRENT_CHOP_MASTER_OFS) begin
                s_d.cfg.chopMaster = req.wrData[CHOP_MASTER_BIT];
            end else if (req.addr == CURRENT_CHOP_CHANNELS_AB_OFS) begin
                s_d.cfg.chopChannels[0] = req.wrData[CHOP_LOW_CHANNEL_BIT];
                s_d.cfg.chopChannels[1] = req.wrData[CHOP_HIGH_CHANNEL_BIT];
            end else if (req.addr == CURRENT_CHOP_CHANNELS_CD_OFS) begin
                s_d.cfg.chopChannels[2] = req.wrData[CHOP_LOW_CHANNEL_BIT];
                s_d.cfg.chopChannels[3] = req.wrData[CHOP_HIGH_CHANNEL_BIT];
            end
        end
        // RL3 boot end address
        s_d.bootEnd = {s_q.cfg.bootRegionSize, 10'h000};
        // RL9 master gates all channels
        for (int i = 0; i < 4; i++) begin
            // RL10 per-channel enable
            s_d.chopOut[i] = s_q.cfg.chopMaster & s_q.cfg.chopChannels[i];
        end
        // RL4 engine clock divider
        s_d.tick = 1'b0;
        if (!s_q.cfg.engineEnable) begin
            s_d.divCnt = 6'h00;
        end else if (s_q.divCnt >= (s_q.cfg.engineFastClockSelect ? FAST_LAST : SLOW_LAST)) begin
            s_d.divCnt = 6'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.divCnt = s_q.divCnt + 6'h01;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            // RL12 reset values
            s_q <= '{cfg: CFG_DEFAULT, bootEnd: {BOOT_REGION_RESET, 10'h000}, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // RL1 converter power
    assign converterEnable = s_q.cfg.converterEnable;
    // RL2 battery load and routing
    assign batteryLoadEnable = s_q.cfg.batteryLoadEnable;
    // RL5 program start
    assign engineProgramStart = s_q.cfg.engineProgramStart;
    assign engineEnable = s_q.cfg.engineEnable;
    assign engineClkEn = s_q.tick;
    assign bootEndAddr = s_q.bootEnd;
    assign currentChopEnable = s_q.chopOut;
    assign rdData = s_q.rd;

    // Chop polarity and alternate frame logic
    mfc_chop_ctrl chop (
        .mclk(mclk),
        .rst_n(rst_n),
        .chopMode(s_q.cfg.chopMode),
        .muxFrameSync(muxFrameSync),
        .accumEnd(accumEnd),
        .chopPolarity(chopPolarity),
        .alternateFrameRequest(alternateFrameRequest)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    conv_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL1
        (req.wrEn && !wake && req.addr == CONVERTER_POWER_CONTROL_OFS)
        |=> converterEnable == $past(req.wrData[CONVERTER_ENABLE_BIT]))
        else $error("converter enable not taken from write");
    batt_wake_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL2
        wake |=> batteryLoadEnable == $past(batteryLoadEnable))
        else $error("battery load changed on wake");
    boot_end_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL3
        ##1 bootEndAddr == {$past(s_q.cfg.bootRegionSize), 10'h000})
        else $error("boot end address not size times 1024");
    fast_tick_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL4
        (engineClkEn && s_q.cfg.engineFastClockSelect && s_q.cfg.engineEnable && !req.wrEn)
        |=> !engineClkEn [*8])
        else $error("engine tick too close");
    prog_wake_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL5
        wake |=> engineProgramStart == PROGRAM_START_RESET)
        else $error("program start not reloaded on wake");
    chop_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL9
        !s_q.cfg.chopMaster |=> currentChopEnable == 4'h0)
        else $error("current chop active without master");
    chan_chop_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL10
        s_q.cfg.chopMaster |=> currentChopEnable == $past(s_q.cfg.chopChannels))
        else $error("channel chop enable mismatch");
    read_back_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL11
        (req.rdEn && req.addr == ENGINE_PROGRAM_BASE_OFS) |=> rdData == $past(engineProgramStart))
        else $error("read back mismatch");
    // The boot end address trails its size register by one cycle, so it is looked at one edge later
    wake_load_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL12
        wake |=> !converterEnable && !engineEnable ##1 bootEndAddr == 18'h00400)
        else $error("wake defaults not loaded");
endmodule

// ### mfc_pkg.sv
// Purpose: Shared constants and types for the metering front-end configuration bank
// Assumes: Byte-wide register port, one 200 MHz clock
// Notes:   Every offset, bit position, reset value and clock count lives here
package mfc_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [15:0] ENGINE_CLOCK_AND_ENABLE_OFS = 16'h2000; // Engine rate and enable
    localparam logic [15:0] BANDGAP_CHOP_CONTROL_OFS = 16'h2002; // Bandgap chop mode
    localparam logic [15:0] CONVERTER_POWER_CONTROL_OFS = 16'h2005; // Converter power
    localparam logic [15:0] BATTERY_TEST_CONTROL_OFS = 16'h2020; // Battery load
    localparam logic [15:0] BOOT_REGION_SIZE_OFS = 16'h20A7; // Boot region size
    localparam logic [15:0] ENGINE_PROGRAM_BASE_OFS = 16'h20A8; // Engine program start
    localparam logic [15:0] CURRENT_CHOP_MASTER_OFS = 16'h20AB; // Current chop master
    localparam logic [15:0] CURRENT_CHOP_CHANNELS_AB_OFS = 16'h20AC; // Channels a and b
    localparam logic [15:0] CURRENT_CHOP_CHANNELS_CD_OFS = 16'h20AD; // Channels c and d

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ENGINE_FAST_CLOCK_BIT = 3; // Fast engine clock select
    localparam int ENGINE_ENABLE_BIT = 4; // Engine enable
    localparam int CHOP_MODE_LSB = 4; // Chop mode low bit
    localparam int CONVERTER_ENABLE_BIT = 3; // Converter and reference enable
    localparam int BATTERY_LOAD_BIT = 6; // Battery load enable
    localparam int CHOP_MASTER_BIT = 0; // Current chop master enable
    localparam int CHOP_LOW_CHANNEL_BIT = 0; // First channel of a pair
    localparam int CHOP_HIGH_CHANNEL_BIT = 4; // Second channel of a pair

    // ----------------------------------------
    // Reset and wake values
    // ----------------------------------------
    localparam logic [7:0] BOOT_REGION_RESET = 8'h01; // Boot region size
    localparam logic [7:0] PROGRAM_START_RESET = 8'h31; // Engine program start
    localparam int BOOT_PAGE_SHIFT = 10; // End address is size times 1024

    // ----------------------------------------
    // Chop mode codes
    // ----------------------------------------
    localparam logic [1:0] CHOP_TOGGLE_ALT = 2'h0; // Toggle, alternate frame at interval end
    localparam logic [1:0] CHOP_POSITIVE = 2'h1; // Forced positive
    localparam logic [1:0] CHOP_REVERSED = 2'h2; // Forced reversed
    localparam logic [1:0] CHOP_TOGGLE_ONLY = 2'h3; // Toggle, never alternate frame

    // ----------------------------------------
    // Engine clock timing
    // ----------------------------------------
    localparam int MCLK_KHZ = 200000; // System clock rate
    localparam int ENGINE_FAST_KHZ = 10000; // Fast engine rate
    localparam int ENGINE_SLOW_KHZ = 5000; // Slow engine rate
    localparam int FAST_DIV = MCLK_KHZ / ENGINE_FAST_KHZ; // Cycles per fast tick
    localparam int SLOW_DIV = MCLK_KHZ / ENGINE_SLOW_KHZ; // Cycles per slow tick
    localparam logic [5:0] FAST_LAST = 6'(FAST_DIV - 1); // Last fast count
    localparam logic [5:0] SLOW_LAST = 6'(SLOW_DIV - 1); // Last slow count

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] addr; // Byte address
        logic wrEn; // Write strobe
        logic rdEn; // Read strobe
        logic [7:0] wrData; // Write data
    } mfc_req_type;

    typedef struct packed {
        logic converterEnable; // Converter and reference powered
        logic batteryLoadEnable; // Battery load applied
        logic engineFastClockSelect; // 10 MHz when set
        logic engineEnable; // Engine running
        logic [1:0] chopMode; // Bandgap chop mode
        logic [7:0] bootRegionSize; // Boot region size
        logic [7:0] engineProgramStart; // Engine program start
        logic chopMaster; // Current chop master
        logic [3:0] chopChannels; // Channel enables a..d
    } mfc_cfg_type;

endpackage

// ### mfc_chop_ctrl.sv
// Purpose: Bandgap chop polarity and alternate frame insertion
// Assumes: Frame sync and interval end are synchronous to mclk
// Notes:   Acts only on the rising edge of the frame sync
`timescale 1ns/1ps
module mfc_chop_ctrl (
    input wire logic mclk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [1:0] chopMode, // Chop mode code
    input wire logic muxFrameSync, // Multiplexer frame sync
    input wire logic accumEnd, // This sync edge ends an accumulation interval
    output logic chopPolarity, // Bandgap chop polarity, 1 is positive
    output logic alternateFrameRequest // One-cycle alternate frame request
);
    import mfc_pkg::*;

    typedef struct packed {
        logic syncPrev; // Sync one cycle ago
        logic pol; // Polarity
        logic altReq; // Alternate frame request
    } mfc_chop_state_type;

    mfc_chop_state_type s_q;
    mfc_chop_state_type s_d;
    logic syncRise; // Rising edge of frame sync

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // Polarity only moves on a sync edge, so a mode change waits for the next frame
    always_comb begin
        s_d = s_q;
        s_d.syncPrev = muxFrameSync;
        s_d.altReq = 1'b0;
        syncRise = muxFrameSync & ~s_q.syncPrev;
        if (syncRise) begin
            // RL6 forced polarity modes
            case (chopMode)
                CHOP_POSITIVE: begin
                    s_d.pol = 1'b1;
                end
                CHOP_REVERSED: begin
                    s_d.pol = 1'b0;
                end
                // RL8 toggle without insertion
                CHOP_TOGGLE_ONLY: begin
                    s_d.pol = ~s_q.pol;
                end
                // RL7 hold and insert at interval end
                default: begin
                    if (accumEnd) begin
                        s_d.altReq = 1'b1;
                    end else begin
                        s_d.pol = ~s_q.pol;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign chopPolarity = s_q.pol;
    assign alternateFrameRequest = s_q.altReq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    forced_pol_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL6
        (muxFrameSync && !s_q.syncPrev && chopMode == CHOP_POSITIVE) |=> chopPolarity)
        else $error("forced positive polarity not applied");
    hold_insert_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL7
        (muxFrameSync && !s_q.syncPrev && chopMode == CHOP_TOGGLE_ALT && accumEnd)
        |=> alternateFrameRequest && $stable(chopPolarity))
        else $error("interval end did not hold polarity and insert frame");
    toggle_only_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL8
        (muxFrameSync && !s_q.syncPrev && chopMode == CHOP_TOGGLE_ONLY)
        |=> !alternateFrameRequest && (chopPolarity != $past(chopPolarity)))
        else $error("toggle-only mode misbehaved");
endmodule

// ### mfc_config_bits_tb.sv
// Purpose: Self-checking bench for the metering front-end configuration bank
// Assumes: Register port and frame sync driven on rising mclk by non-blocking assignment
// Notes:   Shadow copy of every register predicts outputs and read-back
`timescale 1ns/1ps
module mfc_config_bits_tb;
    import mfc_pkg::*;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic mclk = 1'b0; // System clock
    logic rst_n = 1'b0; // Synchronous reset, active low
    logic wake = 1'b0; // Wake pulse
    logic muxFrameSync = 1'b0; // Frame sync
    logic accumEnd = 1'b0; // Interval end marker
    mfc_req_type req = '0; // Register request
    logic [7:0] rdData; // Read data
    logic converterEnable, batteryLoadEnable, engineEnable, engineClkEn; // Single-bit outputs
    logic chopPolarity, alternateFrameRequest; // Chop outputs
    logic [17:0] bootEndAddr; // Boot end address
    logic [7:0] engineProgramStart; // Engine start
    logic [3:0] currentChopEnable; // Channel chop enables
    int errCount = 0; // Mismatches
    int checks = 0; // Comparisons
    logic [31:0] seed = 32'h529E2A01; // Fixed random seed
    logic [15:0] ofs [9] = '{ENGINE_CLOCK_AND_ENABLE_OFS, BANDGAP_CHOP_CONTROL_OFS, CONVERTER_POWER_CONTROL_OFS,
        BATTERY_TEST_CONTROL_OFS, BOOT_REGION_SIZE_OFS, ENGINE_PROGRAM_BASE_OFS, CURRENT_CHOP_MASTER_OFS,
        CURRENT_CHOP_CHANNELS_AB_OFS, CURRENT_CHOP_CHANNELS_CD_OFS}; // Register map
    logic [7:0] mask [9] = '{8'h18, 8'h30, 8'h08, 8'h40, 8'hFF, 8'hFF, 8'h01, 8'h11, 8'h11}; // Defined bits
    logic [7:0] dflt [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h31, 8'h00, 8'h00, 8'h00}; // Reset values
    logic [7:0] shadow [9]; // Expected register contents
    logic expPol; // Expected chop polarity

    always #2.5 mclk = ~mclk;

    mfc_config_bits i_dut (
        .mclk(mclk), .rst_n(rst_n), .wake(wake), .req(req), .rdData(rdData),
        .muxFrameSync(muxFrameSync), .accumEnd(accumEnd), .converterEnable(converterEnable),
        .batteryLoadEnable(batteryLoadEnable), .bootEndAddr(bootEndAddr),
        .engineProgramStart(engineProgramStart), .engineEnable(engineEnable), .engineClkEn(engineClkEn),
        .chopPolarity(chopPolarity), .alternateFrameRequest(alternateFrameRequest),
        .currentChopEnable(currentChopEnable)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Xorshift keeps the run repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Channel enables only count under the master bit
    function automatic logic [3:0] expChop();
        return shadow[6][0] ? {shadow[8][4], shadow[8][0], shadow[7][4], shadow[7][0]} : 4'h0;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.wrData <= d;
        req.wrEn <= 1'b1;
        @(posedge mclk);
        req.wrEn <= 1'b0;
    endtask

    // Read data is looked at in the one cycle it stands
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.rdEn <= 1'b1;
        @(posedge mclk);
        req.rdEn <= 1'b0;
        #1 d = rdData;
    endtask

    // One extra edge lets the lagging outputs settle
    task automatic checkOuts();
        @(posedge mclk);
        #1;
        chk(converterEnable, shadow[2][3]);
        chk(batteryLoadEnable, shadow[3][6]);
        chk(bootEndAddr, {shadow[4], 10'h000});
        chk(engineProgramStart, shadow[5]);
        chk(engineEnable, shadow[0][4]);
        chk(currentChopEnable, expChop());
    endtask

    task automatic checkRegs();
        logic [7:0] v;
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], v);
            chk(v, shadow[i] & mask[i]);
        end
        rd(16'h2001, v);
        chk(v, 32'h0);
    endtask

    task automatic wrs(input int i, input logic [7:0] d);
        wr(ofs[i], d);
        shadow[i] = d & mask[i];
        checkOuts();
    endtask

    // Cycles between engine clock pulses; 0 pulses expected when disabled
    task automatic measure(input int exp);
        int n;
        n = 0;
        while (engineClkEn !== 1'b1 && n < 200) begin
            @(posedge mclk);
            #1 n++;
        end
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (engineClkEn !== 1'b1 && n < 200);
        chk(n, exp);
    endtask

    task automatic sync(input logic ae, input logic [1:0] mode);
        @(posedge mclk);
        muxFrameSync <= 1'b1;
        accumEnd <= ae;
        @(posedge mclk);
        muxFrameSync <= 1'b0;
        accumEnd <= 1'b0;
        case (mode)
            2'h1: expPol = 1'b1;
            2'h2: expPol = 1'b0;
            2'h0: expPol = ae ? expPol : ~expPol;
            default: expPol = ~expPol;
        endcase
        #1 chk(chopPolarity, expPol);
        chk(alternateFrameRequest, mode == 2'h0 && ae);
        @(posedge mclk);
        #1 chk(alternateFrameRequest, 32'h0);
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog, far beyond the thousand or so cycles expected
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge mclk);
        errCount++;
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic [1:0] modes [4];
        modes = '{2'h1, 2'h2, 2'h0, 2'h3};
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) shadow[i] = dflt[i];
        expPol = 1'b0;
        checkOuts();
        checkRegs();
        $display("Test reset values done");
        // Corner: channels set but master toggled
        wrs(7, 8'hFF);
        wrs(8, 8'h10);
        wrs(6, 8'hFF);
        wrs(6, 8'hFE);
        repeat (60) begin
            r = rnd();
            wrs(r % 9, r[15:8]);
        end
        wr(16'h2003, 8'hFF);
        checkRegs();
        $display("Test random writes done");
        wrs(0, 8'h18);
        measure(FAST_DIV);
        wrs(0, 8'h10);
        measure(SLOW_DIV);
        wrs(0, 8'h08);
        measure(200);
        $display("Test engine clock done");
        for (int m = 0; m < 4; m++) begin
            wrs(1, {2'b00, modes[m], 4'h0});
            sync(1'b1, modes[m]);
            sync(1'b0, modes[m]);
            repeat (4) begin
                r = rnd();
                sync(r[0], modes[m]);
            end
        end
        $display("Test chop modes done");
        wrs(3, 8'h40);
        wrs(4, 8'hAB);
        wrs(2, 8'h08);
        // wake beats a write in the same cycle
        @(posedge mclk);
        wake <= 1'b1;
        req.addr <= ofs[5];
        req.wrData <= 8'h77;
        req.wrEn <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        req.wrEn <= 1'b0;
        for (int i = 0; i < 9; i++) shadow[i] = (i == 3) ? shadow[i] : dflt[i];
        checkOuts();
        checkRegs();
        $display("Test wake done");
        give_verdict();
    end
endmodule
